// [core/amp_prot_pkg.sv]
// Constants shared by the output protection top and its half-bridge slices.
// Assumes a 100 MHz system clock and four half-bridges labelled A to D.
package amp_prot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int CLK_PERIOD_NS = 10;             // System clock period in ns.
  localparam int CLIP_MIN_NS   = 500;            // Shortest clip pulse in ns.
  // Least time, so it rounds up to whole cycles.
  localparam int CLIP_MIN_CYC  = (CLIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_SHORT_CHECK_MS_PER_UF = 15;            // Check time per uF of filter, in ms.
  localparam int CYC_PER_MS    = 1_000_000 / CLK_PERIOD_NS;  // Cycles in one ms.
  // Longest time per step for one uF, so it rounds down.
  localparam int PIN_SHORT_CHECK_STEP_CYC_UF = (PIN_SHORT_CHECK_MS_PER_UF * CYC_PER_MS) / 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;    // Output configuration and enables.
  localparam logic [7:0] ADDR_STATUS = 8'h04;    // Protection status, read only.
  localparam logic [7:0] ADDR_COUNT  = 8'h08;    // Overload counters, read only.
  localparam logic [7:0] ADDR_DC_THR = 8'h0c;    // DC imbalance threshold.

  // Config fields and reset values.
  localparam int CFG_MODE_LSB = 0;               // Output configuration, two bits.
  localparam int CFG_DC_EN    = 2;               // DC imbalance protection enable.
  localparam logic [1:0] OUT_BTL  = 2'h0;        // Bridge-tied outputs.
  localparam logic [1:0] OUT_PARALLEL_BRIDGE_CONFIG = 2'h1;        // Parallel bridge output.
  localparam logic [1:0] OUT_SE   = 2'h2;        // Single-ended outputs.
  localparam logic [1:0] CFG_MODE_RST = OUT_BTL;
  localparam logic       CFG_DC_RST   = 1'b1;
  localparam logic [7:0] DC_THR_RST   = 8'h80;

  // Status fields.
  localparam int ST_HIZ_LSB  = 0;                // Four half-bridge Hi-Z bits.
  localparam int ST_TRIP_LSB = 4;                // Four latched trip bits.
  localparam int ST_PIN_SHORT_CHECK_OK  = 8;                // Pin-short check finished.
  localparam int ST_CBC      = 9;                // Cycle limiting mode chosen.
  localparam int ST_LVL_LSB  = 10;               // Trip level index, two bits.
  localparam int ST_AMPS_LSB = 16;               // Trip level in tenths of an ampere.

  ////////////////////////////////////////////////////////////////////////////
  // Limit select bands, in kilohm, and trip levels in tenths of an ampere.
  localparam logic [7:0] CBC_R0 = 8'd22;
  localparam logic [7:0] CBC_R1 = 8'd24;
  localparam logic [7:0] CBC_R2 = 8'd27;
  localparam logic [7:0] CBC_R3 = 8'd30;
  localparam logic [7:0] LAT_R0 = 8'd47;
  localparam logic [7:0] LAT_R1 = 8'd51;
  localparam logic [7:0] LAT_R2 = 8'd56;
  localparam logic [7:0] LAT_R3 = 8'd64;
  localparam logic [7:0] AMPS_L0 = 8'd170;
  localparam logic [7:0] AMPS_L1 = 8'd157;
  localparam logic [7:0] AMPS_L2 = 8'd142;
  localparam logic [7:0] AMPS_L3 = 8'd129;
  localparam logic [1:0] LVL_LOWEST = 2'h3;      // Index of the lowest trip level.

  // Pin-short check sequence.
  typedef enum logic [1:0] {PS_GND, PS_SUP, PS_DONE} pin_short_check_state_t;

endpackage

// [core/hb_prot_if.sv]
// Interface that joins the protection top to one half-bridge slice.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface hb_prot_if #(parameter int OVL_W = 8);
  logic             frame_start;  // First cycle of a PWM frame.
  logic             cbc_mode;     // Cycle limiting mode, else latched mode.
  logic             oc_event;     // One-cycle overcurrent event.
  logic             dc_event;     // One-cycle DC imbalance event.
  logic             clear;        // Reset cycle clears latched state.
  logic             flip;         // Output state flipped for this frame.
  logic             trip;         // Latched shutdown of this half-bridge.
  logic [OVL_W-1:0] count;        // Overload counter value.

  // The top drives events and mode.
  modport ctl (output frame_start, cbc_mode, oc_event, dc_event, clear,
               input flip, trip, count);
  // The slice answers with its flip, trip and counter.
  modport hb (input frame_start, cbc_mode, oc_event, dc_event, clear,
              output flip, trip, count);
endinterface

// [core/hb_protect.sv]
// One half-bridge slice: flip state, overload counter and latched trip.
// Assumes event inputs are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module hb_protect
  import amp_prot_pkg::*;
#(
  parameter int OVL_W = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link to the protection top.
  hb_prot_if.hb    bus
);

  localparam logic [OVL_W-1:0] OVL_MAX = {OVL_W{1'b1}};  // Counter ceiling.

  logic             flip_r;      // Flipped output state.
  logic             oc_seen_r;   // An overcurrent hit in the current frame.
  logic             trip_r;      // Latched shutdown.
  logic [OVL_W-1:0] count_r;     // Overload counter.
  logic [OVL_W-1:0] count_nxt;
  logic             flip_nxt;
  logic             trip_nxt;
  logic             inc;
  logic             dec;

  // An event at a frame start still flips the new frame, the set wins.
  assign flip_nxt = (bus.cbc_mode && bus.oc_event) ? 1'b1 :         // [R2]
                    bus.frame_start ? 1'b0 : flip_r;                 // [R2]
  // Count up per hit, down per clean frame.
  assign inc = (bus.cbc_mode && bus.oc_event) || bus.dc_event;       // [R3] [R11]
  assign dec = bus.frame_start && !oc_seen_r && !bus.oc_event;       // [R3]
  // Saturating counter, increment takes priority over decrement.
  assign count_nxt = bus.clear ? '0 :                                // [R22]
                     (inc && count_r != OVL_MAX) ? count_r + 1'b1 :  // [R22]
                     (inc || !dec || count_r == '0) ? count_r :      // [R22]
                     count_r - 1'b1;
  // Trip on full counter, or at once in latched mode.
  assign trip_nxt = bus.clear ? 1'b0 :                               // [R4]
                    (count_r == OVL_MAX) ? 1'b1 :                    // [R4] [R11]
                    (!bus.cbc_mode && bus.oc_event) ? 1'b1 : trip_r; // [R5]

  // State registers of the slice.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flip_r    <= 1'b0;
      oc_seen_r <= 1'b0;
      trip_r    <= 1'b0;
      count_r   <= '0;
    end else begin
      flip_r    <= flip_nxt;
      oc_seen_r <= bus.oc_event || (oc_seen_r && !bus.frame_start);
      trip_r    <= trip_nxt;
      count_r   <= count_nxt;
    end
  end

  assign bus.flip  = flip_r;
  assign bus.trip  = trip_r;
  assign bus.count = count_r;

endmodule

// [core/amp_output_protection.sv]
// Output protection for a four half-bridge class-D stage with AHB-Lite registers.
// Assumes analog flags arrive asynchronously and frame_start comes from local PWM logic.
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps

// Functional notes
// [R1] Both switches compared; each half-bridge independent.
// [R2] Overcurrent flips output until next frame.
// [R3] Counter up per event, down per clean frame.
// [R4] Full counter shuts channel until reset cycle.
// [R5] Latched mode trips on first overcurrent.
// [R6] Select input picks mode and trip level.
// [R7] Out-of-range select uses lowest threshold.
// [R8] Saturated: inject pulse every fourth frame.
// [R9] Clip pulls warning low, self clearing.
// [R10] Clip pulses start about 500 ns wide.
// [R11] DC imbalance counts up, trips at maximum.
// [R12] DC protection off in single-ended.
// [R13] Pin-short check only at power-up.
// [R14] Short found: all Hi-Z until cleared.
// [R15] Check ground shorts, then supply shorts.
// [R16] Check duration scales with filter capacitance.
// [R17] During check fault low, reset ignored.
// [R18] Reset never reruns check; skipped single-ended (never skipped here: mode is still BTL in the first cycle).
// [R19] Reset low forces fault output released.
// [R20] Controller waits 4 ms before raising reset.
// [R21] Shutdown gives Hi-Z and fault low.
// [R22] Counter saturates both ways, reset clears.
module amp_output_protection
  import amp_prot_pkg::*;
#(
  parameter int OVL_W     = 8,     // Overload counter width.
  parameter int FILTER_UF = 1,     // Output filter capacitance in uF.
  parameter int PIN_SHORT_CHECK_STEP_CYC = PIN_SHORT_CHECK_STEP_CYC_UF * FILTER_UF  // Cycles per check step.
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Asynchronous sense pins.
  input  wire logic [3:0]  oc_high_side,
  input  wire logic [3:0]  oc_low_side,
  input  wire logic [1:0]  dc_unbalance,
  input  wire logic        clip_detect,
  input  wire logic        short_to_gnd,
  input  wire logic        short_to_supply,
  input  wire logic [7:0]  current_limit_select,
  input  wire logic        dev_reset_n,
  // PWM frame timing from the modulator.
  input  wire logic        frame_start,
  // Power stage control.
  output logic [3:0]       hb_hiz,
  output logic [3:0]       hb_flip,
  output logic [3:0]       inject_pulse,
  output logic [1:0]       trip_level,
  output logic [7:0]       dc_threshold,
  output logic             pin_short_check_gnd_test,
  output logic             pin_short_check_supply_test,
  // Open-drain flags, enable low while pulling low.
  output logic             fault_n_o,
  output logic             fault_n_oe_n,
  output logic             clip_warning_n_o,
  output logic             clip_warning_n_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.
  initial begin
    if (OVL_W < 2 || OVL_W > 8) $error("OVL_W must lie in 2..8");
    if (PIN_SHORT_CHECK_STEP_CYC < 1) $error("PIN_SHORT_CHECK_STEP_CYC must be at least 1");
  end

  localparam int SYNC_W = 22;      // Width of the synchronised pin vector.

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before any logic.
  logic [SYNC_W-1:0] pin_raw;      // Pins gathered into one vector.
  logic [SYNC_W-1:0] sync1_r;      // First stage, read only by the second.
  logic [SYNC_W-1:0] sync2_r;      // Second stage, safe to use.

  assign pin_raw = {current_limit_select, dev_reset_n, short_to_supply, short_to_gnd,
                    clip_detect, dc_unbalance, oc_low_side, oc_high_side};

  // Two-stage synchroniser for every asynchronous pin.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  wire logic [3:0] oc_s       = sync2_r[3:0] | sync2_r[7:4];    // Either switch trips. [R1]
  wire logic [1:0] dc_s       = sync2_r[9:8];
  wire logic       clip_s     = sync2_r[10];
  wire logic       sgnd_s     = sync2_r[11];
  wire logic       ssup_s     = sync2_r[12];
  wire logic       rst_s_n    = sync2_r[13];
  wire logic [7:0] sel_s      = sync2_r[21:14];

  ////////////////////////////////////////////////////////////////////////////
  // Limit select decoding.
  // Returns {cbc, level}; values outside both bands give the lowest level.
  function automatic logic [2:0] limit_decode(input logic [7:0] kohm);
    logic [2:0] r;
    r = {1'b0, LVL_LOWEST};                                          // [R7]
    if (kohm >= CBC_R0 && kohm <= CBC_R3) begin                      // [R6]
      r = (kohm < CBC_R1) ? 3'h4 : (kohm < CBC_R2) ? 3'h5 :
          (kohm < CBC_R3) ? 3'h6 : 3'h7;
    end else if (kohm >= LAT_R0 && kohm <= LAT_R3) begin             // [R6]
      r = (kohm < LAT_R1) ? 3'h0 : (kohm < LAT_R2) ? 3'h1 :
          (kohm < LAT_R3) ? 3'h2 : 3'h3;
    end
    return r;
  endfunction

  wire logic [2:0] lim_dec  = limit_decode(sel_s);
  wire logic       cbc_mode = lim_dec[2];
  wire logic [7:0] amps     = (lim_dec[1:0] == 2'h0) ? AMPS_L0 :
                              (lim_dec[1:0] == 2'h1) ? AMPS_L1 :
                              (lim_dec[1:0] == 2'h2) ? AMPS_L2 : AMPS_L3;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  logic [1:0] cfg_mode_r;          // Output configuration.
  logic [1:0] cfg_mode_nxt;
  logic       cfg_dc_r;            // DC protection enable.
  logic       cfg_dc_nxt;
  logic [7:0] dc_thr_r;            // DC imbalance threshold to the comparator.
  logic [7:0] dc_thr_nxt;

  wire logic single_ended_config    = (cfg_mode_r == OUT_SE);
  wire logic parallel_bridge_config = (cfg_mode_r == OUT_PARALLEL_BRIDGE_CONFIG);

  ////////////////////////////////////////////////////////////////////////////
  // Pin-short check at power-up only.
  pin_short_check_state_t ps_r;               // Check sequence state.
  pin_short_check_state_t ps_nxt;
  logic [31:0] ps_cnt_r;           // Cycles of the current step without a short.
  logic [31:0] ps_cnt_nxt;
  logic        ps_first_r;         // First cycle after power-up.

  wire logic ps_run = (ps_r != PS_DONE);
  wire logic ps_step_end = (ps_cnt_r == 32'(PIN_SHORT_CHECK_STEP_CYC - 1));

  // Step sequencing; a short restarts the step and keeps all bridges Hi-Z.
  always_comb begin
    ps_nxt     = ps_r;
    ps_cnt_nxt = ps_cnt_r;
    unique case (ps_r)
      PS_GND: begin                                                  // [R15]
        if (ps_first_r && single_ended_config) begin                 // [R18]
          ps_nxt = PS_DONE;
        end else if (sgnd_s) begin                                   // [R14]
          ps_cnt_nxt = '0;
        end else if (ps_step_end) begin                              // [R16]
          ps_nxt     = PS_SUP;
          ps_cnt_nxt = '0;
        end else begin
          ps_cnt_nxt = ps_cnt_r + 32'h0000_0001;
        end
      end
      PS_SUP: begin                                                  // [R15]
        if (ssup_s) begin                                            // [R14]
          ps_cnt_nxt = '0;
        end else if (ps_step_end) begin                              // [R16]
          ps_nxt = PS_DONE;
        end else begin
          ps_cnt_nxt = ps_cnt_r + 32'h0000_0001;
        end
      end
      PS_DONE: begin
        ps_nxt = PS_DONE;    // No path back: later shorts and resets never rerun it. [R13] [R18]
      end
    endcase
  end

  // Check state registers, entered only by the power-up reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ps_r       <= PS_GND;                                          // [R13]
      ps_cnt_r   <= '0;
      ps_first_r <= 1'b1;
    end else begin
      ps_r       <= ps_nxt;
      ps_cnt_r   <= ps_cnt_nxt;
      ps_first_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset input handling and event detection.
  logic [3:0] oc_d_r;              // Previous overcurrent levels.
  logic [1:0] dc_d_r;              // Previous imbalance levels.
  logic [1:0] frame_cnt_r;         // Frame counter for pulse injection.

  // Reset is ignored while the check runs.
  wire logic clear_req = !rst_s_n && !ps_run;                        // [R17] [R22]
  wire logic [3:0] oc_ev = oc_s & ~oc_d_r;                           // [R1]
  wire logic dc_ok = cfg_dc_r && !single_ended_config;               // [R12]
  wire logic [1:0] dc_ev = dc_s & ~dc_d_r & {2{dc_ok}};              // [R11] [R12]

  // Edge detectors and frame count.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oc_d_r      <= '0;
      dc_d_r      <= '0;
      frame_cnt_r <= '0;
    end else begin
      oc_d_r      <= oc_s;
      dc_d_r      <= dc_s;
      frame_cnt_r <= frame_start ? frame_cnt_r + 2'h1 : frame_cnt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-bridge slices.
  hb_prot_if #(.OVL_W(OVL_W)) hbi [4] ();
  logic [3:0]         trip_v;      // Latched trips of all slices.
  logic [3:0]         flip_v;      // Flip states of all slices.
  logic [4*OVL_W-1:0] count_v;     // Counters of all slices.

  for (genvar g = 0; g < 4; g++) begin : g_hb
    // A DC imbalance counts on the first half-bridge of its channel.
    assign hbi[g].frame_start = frame_start;
    assign hbi[g].cbc_mode    = cbc_mode;
    assign hbi[g].oc_event    = oc_ev[g] && !ps_run;                 // [R1]
    assign hbi[g].dc_event    = (g % 2 == 0) ? dc_ev[g/2] : 1'b0;    // [R11]
    assign hbi[g].clear       = clear_req;                           // [R4]
    assign trip_v[g]          = hbi[g].trip;
    assign flip_v[g]          = hbi[g].flip;
    assign count_v[g*OVL_W +: OVL_W] = hbi[g].count;
    hb_protect #(.OVL_W(OVL_W)) u_hb (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .bus     (hbi[g])
    );
  end

  // Channel shutdown grouping by output configuration.
  // Single-ended: A stops A+B, B stops A+D, C and D stop C+D.
  wire logic [3:0] off_se   = {trip_v[3] | trip_v[2] | trip_v[1], trip_v[3] | trip_v[2],
                               trip_v[0], trip_v[1] | trip_v[0]};
  wire logic [3:0] off_btl  = {{2{trip_v[3] | trip_v[2]}}, {2{trip_v[1] | trip_v[0]}}};
  wire logic [3:0] off_mask = parallel_bridge_config ? {4{|trip_v}} :
                              single_ended_config ? off_se : off_btl;
  wire logic [3:0] hiz_nxt  = off_mask | {4{ps_run || !rst_s_n}};  // [R14] [R21]
  wire logic       sat_any  = clip_s || (|flip_v);
  wire logic [3:0] inj_nxt  = {4{frame_start && frame_cnt_r == 2'h3}} &
                              ({4{clip_s}} | flip_v);                // [R8]
  // Fault: low during the check, low on shutdown, released while reset is low.
  wire logic fault_pull = ps_run || ((|trip_v) && rst_s_n);          // [R17] [R19] [R21]

  ////////////////////////////////////////////////////////////////////////////
  // Clip warning pulse stretcher.
  logic [7:0] clip_cnt_r;          // Remaining minimum pulse cycles.

  // A clip onset pulls low for at least the minimum width, longer while it lasts.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clip_cnt_r <= '0;
    end else if (clip_s) begin
      clip_cnt_r <= 8'(CLIP_MIN_CYC - 1);                            // [R10]
    end else if (clip_cnt_r != '0) begin
      clip_cnt_r <= clip_cnt_r - 8'h01;                              // [R9]
    end
  end

  // Stage outputs, all from flops.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hb_hiz              <= 4'hf;
      hb_flip             <= '0;
      inject_pulse        <= '0;
      trip_level          <= LVL_LOWEST;
      pin_short_check_gnd_test       <= 1'b0;
      pin_short_check_supply_test    <= 1'b0;
      fault_n_o           <= 1'b0;
      fault_n_oe_n        <= 1'b1;
      clip_warning_n_o    <= 1'b0;
      clip_warning_n_oe_n <= 1'b1;
    end else begin
      hb_hiz              <= hiz_nxt;
      hb_flip             <= flip_v & ~hiz_nxt;                      // [R2]
      inject_pulse        <= inj_nxt & {4{sat_any}} & ~hiz_nxt;      // [R8]
      trip_level          <= lim_dec[1:0];                           // [R6]
      pin_short_check_gnd_test       <= (ps_nxt == PS_GND) && !single_ended_config;  // [R15]
      pin_short_check_supply_test    <= (ps_nxt == PS_SUP);                     // [R15]
      fault_n_oe_n        <= !fault_pull;                            // [R21]
      clip_warning_n_oe_n <= !(clip_s || clip_cnt_r != '0);          // [R9] [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY.
  logic       wr_pend_r;           // A write data phase is in progress.
  logic [7:0] wr_addr_r;           // Byte address of that write.

  wire logic ap_valid = hsel && hready && htrans[1];
  wire logic wr_cfg   = wr_pend_r && (wr_addr_r == ADDR_CONFIG);
  wire logic wr_dc    = wr_pend_r && (wr_addr_r == ADDR_DC_THR);
  wire logic [31:0] status_word = {8'h00, amps, 4'h0, lim_dec[1:0], cbc_mode,
                                   !ps_run, trip_v, hb_hiz};
  wire logic [31:0] count_word  = 32'(count_v);

  assign cfg_mode_nxt = wr_cfg ? hwdata[CFG_MODE_LSB +: 2] : cfg_mode_r;
  assign cfg_dc_nxt   = wr_cfg ? hwdata[CFG_DC_EN] : cfg_dc_r;
  assign dc_thr_nxt   = wr_dc ? hwdata[7:0] : dc_thr_r;

  // Read mux sees next values so a read just after a write returns new data.
  wire logic [31:0] rd_mux =
    (haddr[7:0] == ADDR_CONFIG) ? {29'h0, cfg_dc_nxt, cfg_mode_nxt} :
    (haddr[7:0] == ADDR_STATUS) ? status_word :
    (haddr[7:0] == ADDR_COUNT)  ? count_word :
    (haddr[7:0] == ADDR_DC_THR) ? {24'h0, dc_thr_nxt} : 32'h0000_0000;
  wire logic addr_hit = (haddr[31:8] == 24'h00_0000);

  // Bus phase tracking and register storage.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_r    <= 1'b0;
      wr_addr_r    <= '0;
      hrdata       <= '0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      cfg_mode_r   <= CFG_MODE_RST;
      cfg_dc_r     <= CFG_DC_RST;
      dc_thr_r     <= DC_THR_RST;
      dc_threshold <= DC_THR_RST;
    end else begin
      wr_pend_r    <= ap_valid && hwrite && addr_hit;
      wr_addr_r    <= haddr[7:0];
      hrdata       <= (ap_valid && !hwrite && addr_hit) ? rd_mux : '0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      cfg_mode_r   <= cfg_mode_nxt;
      cfg_dc_r     <= cfg_dc_nxt;
      dc_thr_r     <= dc_thr_nxt;
      dc_threshold <= dc_thr_nxt;                                    // [R11]
    end
  end

endmodule

// [sim/amp_prot_monitor.sv]
// Checker for the output protection top, bound to its instance.
// Assumes it sees only the ports of amp_output_protection.
`timescale 1ns/1ps
module amp_prot_monitor (
  // Clock, reset and watched pins.
  input wire logic       clk_sys, arst_n, dev_reset_n, clip_detect, fault_n_oe_n,
  input wire logic       pin_short_check_gnd_test, pin_short_check_supply_test, clip_warning_n_oe_n,
  input wire logic [3:0] hb_hiz,
  input wire logic [1:0] trip_level,
  input wire logic [7:0] current_limit_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire chk = pin_short_check_gnd_test | pin_short_check_supply_test;  // A check step is running.
  step_one_a: assert property (!(pin_short_check_gnd_test && pin_short_check_supply_test))
    else $error("Both check steps on.");
  step_order_a: assert property ($rose(pin_short_check_supply_test) |-> $past(pin_short_check_gnd_test))
    else $error("Supply step not after ground step.");
  check_fault_a: assert property (chk |-> !fault_n_oe_n)
    else $error("Fault released during check.");
  check_hiz_a: assert property (chk |-> hb_hiz == 4'hf)
    else $error("Switching during check.");
  clip_low_a: assert property (clip_detect [*6] |-> !clip_warning_n_oe_n)
    else $error("Clip not reported.");
  clip_width_a: assert property ($fell(clip_warning_n_oe_n) |=> !clip_warning_n_oe_n [*8])
    else $error("Clip pulse too narrow.");
  low_level_a: assert property ((current_limit_select inside {[31:46]}) [*4] |-> trip_level == 2'h3)
    else $error("Out of range select not lowest.");
  rst_release_a: assert property ((!dev_reset_n && !chk) [*5] |-> fault_n_oe_n)
    else $error("Fault held while reset low.");
endmodule
bind amp_output_protection amp_prot_monitor u_mon (.*);

// [sim/sys_ctl.sv]
// Behavioural system controller driving the device reset pin.
// Assumes the bench resolves the fault pin with its pull-up.
`timescale 1ns/1ps
module sys_ctl #(
  parameter int WAIT_CYC = 400_000  // Least cycles from fault fall to reset rise.
) (
  // Clock and pins.
  input  wire logic clk_sys,
  input  wire logic fault_n,
  input  wire logic go,                // Bench asks for a reset cycle.
  output logic      dev_reset_n = 1'b1
);
  int cnt = 0;  // Cycles since the fault pin fell or reset went low.
  // Reset stays low while asked and until the wait has run out.
  always @(posedge clk_sys) begin
    cnt <= (fault_n && dev_reset_n) ? 0 : cnt + 1;
    dev_reset_n <= !(go || (!dev_reset_n && cnt < WAIT_CYC));
  end
endmodule

// [sim/tb.sv]
// Self-checking bench for the output protection top.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, v); end end
module tb;
  import amp_prot_pkg::*;
  logic clk_sys = 0, arst_n = 0, hwrite = 0, clip_detect = 0, frame_start = 0, go = 0, hsel = 1;
  logic hreadyout, hresp, short_to_gnd = 0, short_to_supply = 0, dev_reset_n, fault_n_o;
  logic fault_n_oe_n, clip_warning_n_o, clip_warning_n_oe_n, pin_short_check_gnd_test, pin_short_check_supply_test;
  logic [1:0] htrans = 0, dc_unbalance = 0, trip_level;
  logic [2:0] hsize = 3'h2;
  logic [3:0] oc_high_side = 0, oc_low_side = 0, hb_hiz, hb_flip, inject_pulse;
  logic [7:0] current_limit_select = 8'h2f, dc_threshold;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0] lv [8] = '{8'h16, 8'h18, 8'h1b, 8'h1e, 8'h2f, 8'h33, 8'h38, 8'h40};
  int n_fail = 0, checked = 0;
  wire hready = hreadyout;
  wire fault_pin = fault_n_oe_n ? 1'b1 : fault_n_o;  // Pull-up unless pulled low.
  wire clip_pin = clip_warning_n_oe_n ? 1'b1 : clip_warning_n_o;
  amp_output_protection #(.OVL_W(3), .PIN_SHORT_CHECK_STEP_CYC(20)) u_dut (.*);
  sys_ctl #(.WAIT_CYC(30)) u_ctl (.clk_sys, .fault_n(fault_pin), .go, .dev_reset_n);
  always #5 clk_sys = ~clk_sys;
  // Frame start pulse every 16 cycles.
  always begin
    repeat (15) @(posedge clk_sys);
    frame_start <= 1;
    @(posedge clk_sys) frame_start <= 0;
  end
  task wt(input int n); repeat (n) @(posedge clk_sys); endtask
  // One single AHB-Lite transfer; read data lands in rd.
  task ahb(input logic w, input logic [31:0] a, d);
    hwrite <= w; haddr <= a; htrans <= 2'h2;
    do @(posedge clk_sys); while (!hreadyout);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk_sys); while (!hreadyout);
    rd = hrdata;
  endtask
  // One overcurrent pulse on the chosen switches.
  task hit(input logic [3:0] h, l);
    oc_high_side <= h; oc_low_side <= l; wt(3);
    oc_high_side <= 0; oc_low_side <= 0; wt(3);
  endtask
  task summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin #100us; n_fail++; summarize; end
  initial begin
    wt(3); arst_n <= 1;
    wt(30); `CHK("fault_check", 1'b0, fault_pin)
    wt(30); `CHK("fault_done", 1'b1, fault_pin)
    ahb(0, 32'h4, 0); `CHK("status_done", 1'b1, rd[ST_PIN_SHORT_CHECK_OK])
    ahb(0, 32'hc, 0); `CHK("thr_rst", 32'h80, rd)
    ahb(1, 32'hc, 32'h55); ahb(0, 32'hc, 0); `CHK("thr", 32'h55, rd)
    `CHK("thr_out", 8'h55, dc_threshold)
    ahb(0, 32'h20, 0); `CHK("unmapped", 32'h0, rd)
    foreach (lv[i]) begin
      current_limit_select <= lv[i]; wt(6); `CHK("level", i[1:0], trip_level)
    end
    current_limit_select <= 8'h28; wt(6); `CHK("lowest", 2'h3, trip_level)
    hit(4'h1, 0); wt(4); `CHK("latched_hiz", 4'h3, hb_hiz)
    `CHK("fault_low", 1'b0, fault_pin)
    go <= 1; wt(8); `CHK("rst_fault", 1'b1, fault_pin)
    go <= 0; wt(50); `CHK("hiz_clear", 4'h0, hb_hiz)
    current_limit_select <= 8'h16; wt(6);
    @(posedge clk_sys iff frame_start);
    hit(0, 4'h4); `CHK("flip", 4'h4, hb_flip)
    ahb(0, 32'h8, 0); `CHK("count_up", 3'h1, rd[8:6])
    wt(20); `CHK("flip_clear", 4'h0, hb_flip)
    wt(40); ahb(0, 32'h8, 0); `CHK("count_down", 3'h0, rd[8:6])
    repeat (8) hit(0, 4'h8);
    wt(4); `CHK("ovl_hiz", 4'hc, hb_hiz)
    clip_detect <= 1; wt(10); `CHK("clip_low", 1'b0, clip_pin)
    rd = 0; repeat (80) @(posedge clk_sys) rd |= inject_pulse;
    `CHK("inject", 32'h3, rd)
    clip_detect <= 0; wt(70); `CHK("clip_clear", 1'b1, clip_pin)
    @(posedge clk_sys iff frame_start); dc_unbalance <= 1; wt(4); dc_unbalance <= 0;
    ahb(0, 32'h8, 0); `CHK("dc_count", 3'h1, rd[2:0])
    ahb(1, 32'h0, 32'h6); @(posedge clk_sys iff frame_start); dc_unbalance <= 1; wt(4);
    ahb(0, 32'h8, 0); `CHK("dc_se", 3'h0, rd[2:0])
    summarize;
  end
endmodule
